/* irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

  // Width of the device control register bus address and data.
  localparam int DCR_ADDR_W = 10;
  localparam int DCR_DATA_W = 32;
  localparam int NUM_SRC    = 32;
  localparam int NUM_PINS   = 7;
  localparam int NUM_DMA    = 4;

  // Register addresses on the device control register bus.
  localparam logic [DCR_ADDR_W-1:0] ADDR_STATUS   = 10'h0C0;
  localparam logic [DCR_ADDR_W-1:0] ADDR_ENABLE   = 10'h0C2;
  localparam logic [DCR_ADDR_W-1:0] ADDR_CLASS    = 10'h0C3;
  localparam logic [DCR_ADDR_W-1:0] ADDR_POLARITY = 10'h0C4;
  localparam logic [DCR_ADDR_W-1:0] ADDR_TRIGGER  = 10'h0C5;
  localparam logic [DCR_ADDR_W-1:0] ADDR_MASKED   = 10'h0C6;

  // Source positions within every per-source register.
  localparam int POS_SERIAL0   = 0;
  localparam int POS_SERIAL1   = 1;
  localparam int POS_TWOWIRE   = 2;
  localparam int POS_EXTMASTER = 3;
  localparam int POS_DMA_LO    = 5;
  localparam int POS_DMA_HI    = 8;
  localparam int POS_ECC       = 17;
  localparam int POS_PIN_LO    = 25;
  localparam int POS_PIN_HI    = 31;

  // Implemented bits; reserved positions 4, 9..16 and 18..24 are zero.
  localparam logic [NUM_SRC-1:0] VALID_MASK    = 32'hFE02_01EF;
  localparam logic [NUM_SRC-1:0] INTERNAL_MASK = 32'h0002_01EF;

  // Reset values of the software registers.
  localparam logic [NUM_SRC-1:0] ENABLE_RST   = 32'h0000_0000;
  localparam logic [NUM_SRC-1:0] CLASS_RST    = 32'h0000_0000;
  localparam logic [NUM_SRC-1:0] POLARITY_RST = 32'hFE02_01EF;
  localparam logic [NUM_SRC-1:0] TRIGGER_RST  = 32'h0000_0008;
  localparam logic [NUM_SRC-1:0] STATUS_RST   = 32'h0000_0000;
  localparam logic [NUM_SRC-1:0] ZERO_WORD    = 32'h0000_0000;

  // One request on the device control register bus.
  typedef struct packed {
    logic [DCR_ADDR_W-1:0] addr;
    logic                  rd;
    logic                  wr;
    logic [DCR_DATA_W-1:0] wdata;
  } dcr_req_t;

endpackage

/* irq_sync2.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for asynchronous request pins.
module irq_sync2
  import irq_ctrl_pkg::*;
#(
  parameter int WIDTH = 7
)
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] stable_nxt;

  // The first stage feeds only the second stage.
  always_comb
  begin
    meta_nxt   = async_in;
    stable_nxt = meta_r;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_r   <= '0;
      stable_r <= '0;
    end
    else
    begin
      meta_r   <= meta_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign sync_out = stable_r;

endmodule

/* irq_source_detect.sv */
`timescale 1ns/10ps
// Per-source polarity correction and level or edge event detection.
module irq_source_detect
  import irq_ctrl_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] raw_req,
  input  wire logic [WIDTH-1:0] polarity,
  input  wire logic [WIDTH-1:0] edge_mode,
  output logic      [WIDTH-1:0] event_req
);

  logic [WIDTH-1:0] active;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;

  // A one in polarity treats the request as active high, a zero as active low.
  always_comb
  begin
    active    = ~(raw_req ^ polarity);
    prev_nxt  = active;
    event_req = (edge_mode & active & ~prev_r) | (~edge_mode & active);
  end

  // History starts inactive, so an asserted edge source fires once after reset.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      prev_r <= '0;
    end
    else
    begin
      prev_r <= prev_nxt;
    end
  end

endmodule

/* interrupt_controller_regs.sv */
`timescale 1ns/10ps
module interrupt_controller_regs
  import irq_ctrl_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire dcr_req_t              dcr_req,
  output logic      [DCR_DATA_W-1:0] dcr_rdata_r,
  output logic                       dcr_ack_r,
  input  wire logic                  serial0_req,
  input  wire logic                  serial1_req,
  input  wire logic                  twowire_req,
  input  wire logic                  ext_master_req,
  input  wire logic [NUM_DMA-1:0]    dma_req,
  input  wire logic                  ecc_error_req,
  input  wire logic [NUM_PINS-1:0]   external_request_pins,
  output logic                       critical_irq_r,
  output logic                       noncritical_irq_r
);

  // Every register below has a next-value partner computed in combinational logic
  // and loaded in the single clocked process at the bottom of the module.
  // Keeping all software and output registers in one flop process makes the reset values easy to audit.
  // Reserved positions are held at zero by masking on every write path, so no
  // read path needs a mask of its own.
  // Software registers and their next values.
  logic [NUM_SRC-1:0]    interrupt_status_r;
  logic [NUM_SRC-1:0]    interrupt_status_nxt;
  logic [NUM_SRC-1:0]    interrupt_enable_r;
  logic [NUM_SRC-1:0]    interrupt_enable_nxt;
  logic [NUM_SRC-1:0]    interrupt_class_r;
  logic [NUM_SRC-1:0]    interrupt_class_nxt;
  logic [NUM_SRC-1:0]    interrupt_polarity_r;
  logic [NUM_SRC-1:0]    interrupt_polarity_nxt;
  logic [NUM_SRC-1:0]    interrupt_trigger_mode_r;
  logic [NUM_SRC-1:0]    interrupt_trigger_mode_nxt;

  // The bus answer and both interrupt lines are registered, so every output
  // of this module comes straight from a flop and carries no decode glitch.
  // The price is one cycle of latency on each of them.
  // Bus answer and interrupt outputs.
  logic [DCR_DATA_W-1:0] dcr_rdata_nxt;
  logic                  dcr_ack_nxt;
  logic                  critical_irq_nxt;
  logic                  noncritical_irq_nxt;

  // The decode strobes below are purely combinational from the bus request.
  // The request is expected to be driven from the same clock, so no
  // synchroniser sits on the bus side.
  // Decode and source wiring.
  logic [NUM_PINS-1:0]   pins_sync;
  logic [NUM_SRC-1:0]    raw_src;
  logic [NUM_SRC-1:0]    event_src;
  logic [NUM_SRC-1:0]    masked_interrupt_status;
  logic [NUM_SRC-1:0]    status_clear;
  logic                  wr_status;
  logic                  wr_enable;
  logic                  wr_class;
  logic                  wr_polarity;
  logic                  wr_trigger;

  // Only the pins are synchronised; every internal source already runs on mclk.
  // The synchroniser adds two cycles, so a pin event reaches status two cycles
  // later than an internal request does.
  // A pin pulse shorter than one clock period may be missed entirely.
  // Pins come from outside the clock domain and are synchronised first.
  irq_sync2 #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (external_request_pins),
    .sync_out (pins_sync)
  );

  // The slice positions come from the package so the bit layout lives in one place.
  // Any source added later must also be added to the implemented-bit mask.
  // Gather every source into its register position; reserved positions stay zero.
  always_comb
  begin
    raw_src                            = ZERO_WORD;
    raw_src[POS_SERIAL0]               = serial0_req;
    raw_src[POS_SERIAL1]               = serial1_req;
    raw_src[POS_TWOWIRE]               = twowire_req;
    raw_src[POS_EXTMASTER]             = ext_master_req;
    raw_src[POS_DMA_HI:POS_DMA_LO]     = dma_req;
    raw_src[POS_ECC]                   = ecc_error_req;
    raw_src[POS_PIN_HI:POS_PIN_LO]     = pins_sync;
  end

  // Detection sits in front of the status register so that status only ever
  // sees active-high events, whatever the wiring of a pin.
  // A polarity change takes effect at once and can itself look like an event,
  // so software should clear status after reprogramming polarity.
  // Polarity and trigger mode shape each request before it reaches status.
  irq_source_detect #(
    .WIDTH (NUM_SRC)
  ) u_detect (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .raw_req   (raw_src),
    .polarity  (interrupt_polarity_r),
    .edge_mode (interrupt_trigger_mode_r),
    .event_req (event_src)
  );

  // Writes to the masked view and to unmapped addresses fall through to the
  // final branch and change nothing, yet they are still acknowledged.
  // Only one strobe can be high in any cycle, which keeps the register
  // update blocks free of priority questions.
  // The trigger register sits at the address next to polarity.
  // Write decode; an address chain keeps each strobe exclusive.
  always_comb
  begin
    wr_status   = 1'b0;
    wr_enable   = 1'b0;
    wr_class    = 1'b0;
    wr_polarity = 1'b0;
    wr_trigger  = 1'b0;
    if (dcr_req.wr)
    begin
      if (dcr_req.addr == ADDR_STATUS)
      begin
        wr_status = 1'b1;
      end
      else if (dcr_req.addr == ADDR_ENABLE)
      begin
        wr_enable = 1'b1;
      end
      else if (dcr_req.addr == ADDR_CLASS)
      begin
        wr_class = 1'b1;
      end
      else if (dcr_req.addr == ADDR_POLARITY)
      begin
        wr_polarity = 1'b1;
      end
      else if (dcr_req.addr == ADDR_TRIGGER)
      begin
        wr_trigger = 1'b1;
      end
      else
      begin
        wr_status = 1'b0;
      end
    end
  end

  // Write-one-to-clear lets software clear exactly the bits it has serviced
  // without a read-modify-write race against new events.
  // A level source that is still active sets its bit again at once, so the
  // handler must first quiet the source and only then clear the status bit.
  // Disabled sources still record events; the enable only gates delivery.
  // Status: a one written clears that bit, but a new event in the same cycle wins.
  always_comb
  begin
    status_clear         = wr_status ? dcr_req.wdata : ZERO_WORD;
    interrupt_status_nxt = ((interrupt_status_r & ~status_clear)
                           | event_src) & VALID_MASK;
  end

  // All four configuration registers are plain read and write storage.
  // Masking on write rather than on read means reserved bits are never stored,
  // which also keeps them out of the interrupt tree.
  // Configuration registers keep only implemented bits so reserved ones read zero.
  always_comb
  begin
    interrupt_enable_nxt       = interrupt_enable_r;
    interrupt_class_nxt        = interrupt_class_r;
    interrupt_polarity_nxt     = interrupt_polarity_r;
    interrupt_trigger_mode_nxt = interrupt_trigger_mode_r;
    if (wr_enable)
    begin
      interrupt_enable_nxt = dcr_req.wdata & VALID_MASK;
    end
    if (wr_class)
    begin
      interrupt_class_nxt = dcr_req.wdata & VALID_MASK;
    end
    if (wr_polarity)
    begin
      // Internal sources are meant to stay active high; the bit is still stored as written.
      interrupt_polarity_nxt = dcr_req.wdata & VALID_MASK;
    end
    if (wr_trigger)
    begin
      interrupt_trigger_mode_nxt = dcr_req.wdata & VALID_MASK;
    end
  end

  // The trade-off is one extra gate level on both the read path and the
  // interrupt path, which is cheap next to a second copy of the status bits.
  // The masked view is never stored, so it can never disagree with its inputs.
  always_comb
  begin
    masked_interrupt_status = interrupt_status_r & interrupt_enable_r;
  end

  // Each masked bit feeds exactly one of the two outputs, chosen by its class.
  // Registering the result keeps glitches of the reduction trees off the
  // interrupt inputs of the core.
  // Interrupt outputs split the masked view by class.
  always_comb
  begin
    critical_irq_nxt    = |(masked_interrupt_status & interrupt_class_r);
    noncritical_irq_nxt = |(masked_interrupt_status & ~interrupt_class_r);
  end

  // Reads have no side effects, so a repeated read is harmless.
  // The data returns with the acknowledge one cycle after the request and
  // is zero in every other cycle, so several slaves can share one return bus.
  // A read sees the register value from before any update in the same cycle.
  // Read mux; an unmapped address answers with zero so the core never hangs.
  always_comb
  begin
    dcr_ack_nxt   = dcr_req.rd | dcr_req.wr;
    dcr_rdata_nxt = ZERO_WORD;
    if (dcr_req.rd)
    begin
      if (dcr_req.addr == ADDR_STATUS)
      begin
        dcr_rdata_nxt = interrupt_status_r;
      end
      else if (dcr_req.addr == ADDR_ENABLE)
      begin
        dcr_rdata_nxt = interrupt_enable_r;
      end
      else if (dcr_req.addr == ADDR_CLASS)
      begin
        dcr_rdata_nxt = interrupt_class_r;
      end
      else if (dcr_req.addr == ADDR_POLARITY)
      begin
        dcr_rdata_nxt = interrupt_polarity_r;
      end
      else if (dcr_req.addr == ADDR_TRIGGER)
      begin
        dcr_rdata_nxt = interrupt_trigger_mode_r;
      end
      else if (dcr_req.addr == ADDR_MASKED)
      begin
        dcr_rdata_nxt = masked_interrupt_status;
      end
      else
      begin
        dcr_rdata_nxt = ZERO_WORD;
      end
    end
  end

  // The reset branch assigns package constants and literal zeros only.
  // Every register loads its next value on each edge; holding is done in the
  // next-value logic rather than by a clock enable.
  // All software and output registers; reset gives a quiet controller with every source disabled.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      interrupt_status_r       <= STATUS_RST;
      interrupt_enable_r       <= ENABLE_RST;
      interrupt_class_r        <= CLASS_RST;
      interrupt_polarity_r     <= POLARITY_RST;
      interrupt_trigger_mode_r <= TRIGGER_RST;
      dcr_rdata_r              <= ZERO_WORD;
      dcr_ack_r                <= 1'b0;
      critical_irq_r           <= 1'b0;
      noncritical_irq_r        <= 1'b0;
    end
    else
    begin
      interrupt_status_r       <= interrupt_status_nxt;
      interrupt_enable_r       <= interrupt_enable_nxt;
      interrupt_class_r        <= interrupt_class_nxt;
      interrupt_polarity_r     <= interrupt_polarity_nxt;
      interrupt_trigger_mode_r <= interrupt_trigger_mode_nxt;
      dcr_rdata_r              <= dcr_rdata_nxt;
      dcr_ack_r                <= dcr_ack_nxt;
      critical_irq_r           <= critical_irq_nxt;
      noncritical_irq_r        <= noncritical_irq_nxt;
    end
  end

endmodule

/* irq_ctrl_regs_assertions.sv */
`timescale 1ns/10ps
module irq_regs_checker
  import irq_ctrl_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire dcr_req_t              dcr_req,
  input wire logic [DCR_DATA_W-1:0] dcr_rdata_r,
  input wire logic                  dcr_ack_r,
  input wire logic [NUM_DMA-1:0]    dma_req,
  input wire logic                  ecc_error_req,
  input wire logic                  critical_irq_r,
  input wire logic                  noncritical_irq_r
);
  logic [NUM_SRC-1:0] en_r;
  logic [NUM_SRC-1:0] en_nxt;
  logic [NUM_SRC-1:0] cl_r;
  logic [NUM_SRC-1:0] cl_nxt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Shadow copies of enable and class, so irq checks need no peek inside.
  always_comb
  begin
    en_nxt = en_r;
    cl_nxt = cl_r;
    if (sys_rst)
    begin
      en_nxt = ENABLE_RST;
      cl_nxt = CLASS_RST;
    end
    else if (dcr_req.wr && dcr_req.addr == ADDR_ENABLE)
      en_nxt = dcr_req.wdata & VALID_MASK;
    else if (dcr_req.wr && dcr_req.addr == ADDR_CLASS)
      cl_nxt = dcr_req.wdata & VALID_MASK;
  end

  // Registers only; reset is folded into the next-value logic.
  always_ff @(posedge mclk)
  begin
    en_r <= en_nxt;
    cl_r <= cl_nxt;
  end

  ack_follows_a: assert property ((dcr_req.rd || dcr_req.wr) |=> dcr_ack_r)
    else $error("bus access not acknowledged");
  ack_cause_a: assert property (!(dcr_req.rd || dcr_req.wr) |=> !dcr_ack_r)
    else $error("acknowledge without access");
  rdata_idle_a: assert property (!dcr_ack_r |-> dcr_rdata_r == ZERO_WORD)
    else $error("read data not zero outside acknowledge");
  reserved_zero_a: assert property (dcr_ack_r |-> (dcr_rdata_r & ~VALID_MASK) == ZERO_WORD)
    else $error("reserved bit read as one");
  enable_readback_a: assert property ((dcr_req.wr && dcr_req.addr == ADDR_ENABLE) ##1
    (dcr_req.rd && dcr_req.addr == ADDR_ENABLE) |=> dcr_rdata_r == ($past(dcr_req.wdata, 2) & VALID_MASK))
    else $error("enable register readback wrong");
  irq_quiet_a: assert property ($past(en_r) == ZERO_WORD |-> !critical_irq_r && !noncritical_irq_r)
    else $error("interrupt output with all sources disabled");
  ecc_crit_a: assert property (ecc_error_req && en_r[POS_ECC] && cl_r[POS_ECC] |-> ##[1:3] critical_irq_r)
    else $error("enabled critical ecc request not delivered");
  dma_noncrit_a: assert property ((dma_req & en_r[POS_DMA_HI:POS_DMA_LO] & ~cl_r[POS_DMA_HI:POS_DMA_LO]) != 0
    |-> ##[1:3] noncritical_irq_r)
    else $error("enabled non-critical dma request not delivered");
endmodule

bind interrupt_controller_regs irq_regs_checker irq_regs_checker_inst (
  .mclk              (mclk),
  .sys_rst           (sys_rst),
  .dcr_req           (dcr_req),
  .dcr_rdata_r       (dcr_rdata_r),
  .dcr_ack_r         (dcr_ack_r),
  .dma_req           (dma_req),
  .ecc_error_req     (ecc_error_req),
  .critical_irq_r    (critical_irq_r),
  .noncritical_irq_r (noncritical_irq_r)
);

/* irq_source_model.sv */
`timescale 1ns/10ps
module irq_source_model
  import irq_ctrl_pkg::*;
(
  input  wire logic [NUM_SRC-1:0]  want,
  input  wire logic [NUM_PINS-1:0] active_low,
  output logic                     serial0_req,
  output logic                     serial1_req,
  output logic                     twowire_req,
  output logic                     ext_master_req,
  output logic [NUM_DMA-1:0]       dma_req,
  output logic                     ecc_error_req,
  output logic [NUM_PINS-1:0]      external_request_pins
);
  // Internal sources are always active high, so their polarity stays one.
  assign serial0_req    = want[POS_SERIAL0];
  assign serial1_req    = want[POS_SERIAL1];
  assign twowire_req    = want[POS_TWOWIRE];
  assign ext_master_req = want[POS_EXTMASTER];
  assign dma_req        = want[POS_DMA_HI:POS_DMA_LO];
  assign ecc_error_req  = want[POS_ECC];
  // Pins wired active low idle high, so the line level flips with the mode.
  assign external_request_pins = want[POS_PIN_HI:POS_PIN_LO] ^ active_low;
endmodule

/* tb.sv */
`timescale 1ns/10ps
module tb;
  import irq_ctrl_pkg::*;
  logic                  mclk = 1'b0;
  logic                  sys_rst;
  dcr_req_t              dcr_req;
  logic [DCR_DATA_W-1:0] dcr_rdata_r;
  logic                  dcr_ack_r;
  logic                  serial0_req;
  logic                  serial1_req;
  logic                  twowire_req;
  logic                  ext_master_req;
  logic                  ecc_error_req;
  logic [NUM_DMA-1:0]    dma_req;
  logic [NUM_PINS-1:0]   external_request_pins;
  logic [NUM_PINS-1:0]   active_low;
  logic [NUM_SRC-1:0]    want;
  logic [NUM_SRC-1:0]    rd_val;
  logic                  critical_irq_r;
  logic                  noncritical_irq_r;
  logic                  en;
  logic                  cls;
  int                    errors;
  int                    n_checks;
  int                    cycles;
  int                    pos[18] = '{0, 1, 2, 3, 5, 6, 7, 8, 17, 25, 26, 27, 28, 29, 30, 31, 0, 1};

  // Clock, and a ceiling well above the roughly 450 cycles the tests need.
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      summarize();
    end
  end

  interrupt_controller_regs interrupt_controller_regs_inst (.*);
  irq_source_model irq_source_model_inst (.*);

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One access: the request stands for the taking edge, and the answer stands in the cycle after it.
  // An idle edge follows, so the next call never lands in the same time step as this release.
  task access(input logic [DCR_ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    dcr_req = '{addr: a, rd: !w, wr: w, wdata: d};
    @(posedge mclk);
    #1;
    dcr_req = '0;
    rd_val = dcr_rdata_r;
    chk("ack", 32'h1, {31'h0, dcr_ack_r});
    @(posedge mclk);
    #1;
  endtask

  task rd(input logic [DCR_ADDR_W-1:0] a, input logic [31:0] exp);
    access(a, 1'b0, 32'h0);
    chk($sformatf("register %h", a), exp, rd_val);
  endtask

  // Main sequence: reset values, register access, then every source in turn.
  initial
  begin
    dcr_req = '0;
    want = '0;
    active_low = '0;
    sys_rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    rd(ADDR_STATUS, STATUS_RST);
    rd(ADDR_ENABLE, ENABLE_RST);
    rd(ADDR_CLASS, CLASS_RST);
    rd(ADDR_POLARITY, POLARITY_RST);
    rd(ADDR_TRIGGER, TRIGGER_RST);
    rd(ADDR_MASKED, ZERO_WORD);
    rd(10'h0C1, ZERO_WORD);
    $display("test reset values done");
    access(ADDR_MASKED, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_MASKED, ZERO_WORD);
    access(ADDR_CLASS, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_CLASS, VALID_MASK);
    access(ADDR_TRIGGER, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_TRIGGER, VALID_MASK);
    access(ADDR_TRIGGER, 1'b1, TRIGGER_RST);
    access(ADDR_POLARITY, 1'b1, 32'h0002_01EF);
    rd(ADDR_POLARITY, 32'h0002_01EF);
    // Write then read back to back; the read data stands in the cycle after the read edge.
    dcr_req = '{addr: ADDR_ENABLE, rd: 1'b0, wr: 1'b1, wdata: 32'hFFFF_FFFF};
    @(posedge mclk);
    #1;
    dcr_req.wr = 1'b0;
    dcr_req.rd = 1'b1;
    @(posedge mclk);
    #1;
    dcr_req = '0;
    chk("enable back to back", VALID_MASK, dcr_rdata_r);
    @(posedge mclk);
    #1;
    access(ADDR_ENABLE, 1'b1, 32'h0);
    $display("test register access done");
    active_low = 7'h55;
    access(ADDR_POLARITY, 1'b1, POLARITY_RST & ~{7'h55, 25'h0});
    repeat (4) @(posedge mclk);
    #1;
    access(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, ZERO_WORD);
    for (int i = 0; i < 16; i++)
    begin
      en = !i[0];
      cls = i[3] ^ i[1];
      access(ADDR_ENABLE, 1'b1, {31'h0, en} << pos[i]);
      access(ADDR_CLASS, 1'b1, {31'h0, cls} << pos[i]);
      want = 32'h1 << pos[i];
      repeat (6) @(posedge mclk);
      #1;
      chk("critical", {31'h0, en & cls}, {31'h0, critical_irq_r});
      chk("noncritical", {31'h0, en & !cls}, {31'h0, noncritical_irq_r});
      rd(ADDR_MASKED, {31'h0, en} << pos[i]);
      want = '0;
      repeat (6) @(posedge mclk);
      #1;
      rd(ADDR_STATUS, 32'h1 << pos[i]);
      access(ADDR_STATUS, 1'b1, 32'h1 << pos[i]);
      rd(ADDR_STATUS, ZERO_WORD);
      chk("outputs idle", 32'h0, {30'h0, critical_irq_r, noncritical_irq_r});
    end
    $display("test source delivery done");
    // Clear while serial0 (level) and the external master (edge) are both held active.
    want = 32'h0000_0009;
    repeat (4) @(posedge mclk);
    #1;
    access(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, 32'h0000_0001);
    want = '0;
    repeat (4) @(posedge mclk);
    #1;
    access(ADDR_STATUS, 1'b1, 32'hFFFF_FFFF);
    rd(ADDR_STATUS, ZERO_WORD);
    $display("test edge and level done");
    summarize();
  end
endmodule
